/* File: rtl/ldm_line_diag_measurement.sv */
// diagnostic measurement path behind the monitor converter
//
// Summary of operation
// - dc location holds low-pass filtered converter level
// - dc filter coefficient from bits 15:3
// - ac rms filter coefficient from bits 15:3
// - peak location holds filtered peak amplitude
// - monitor input select steers converter source
// - loop current refreshed 800 Hz, sign-magnitude
// - longitudinal current refreshed 800 Hz, sign-magnitude
// - ring transistor current two's complement, 16 bit
// - coefficients and results reset to zero
// - ac location holds rms value, below 300 Hz
`timescale 1ns/10ps
`default_nettype none
module ldm_line_diag_measurement #(
    parameter int REFRESH_CYC = ldm_pkg::LDM_REFRESH_CYC,
    parameter int SEL_W       = 4
) (
    input  wire logic                            clk,
    input  wire logic                            rst_n,
    input  wire logic [ldm_pkg::LDM_ADDR_W-1:0]  ramAddr,
    input  wire logic                            ramWrEn,
    input  wire logic [ldm_pkg::LDM_DATA_W-1:0]  ramWrData,
    input  wire logic                            ramRdEn,
    output logic      [ldm_pkg::LDM_DATA_W-1:0]  ramRdData,
    output logic                                 ramRdValid,
    input  wire logic [SEL_W-1:0]                monitorInputSelect,
    output logic      [SEL_W-1:0]                monitorSelOut,
    input  wire logic signed [15:0]              adcSample,
    input  wire logic                            adcValid,
    input  wire logic signed [15:0]              loopCurrentIn,
    input  wire logic signed [15:0]              longCurrentIn,
    input  wire logic signed [15:0]              ringCurrentIn,
    input  wire logic                            ringCurrentValid
);
    import ldm_pkg::*;
    // refuse settings the refresh counter or select path cannot serve
    if (REFRESH_CYC < 2 || SEL_W < 1) begin : gCheck
        $error("REFRESH_CYC must be at least 2 and SEL_W at least 1");
    end
    localparam int CNT_W = $clog2(REFRESH_CYC);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(REFRESH_CYC - 1);
    // one step of a first order filter in 16.16 fixed point
    function automatic logic signed [31:0] lpfStep(
        input logic signed [31:0] acc,
        input logic signed [31:0] tgt,
        input logic        [15:0] k
    );
        logic signed [32:0] diff;
        logic signed [49:0] prod;
        diff = $signed({tgt[31], tgt}) - $signed({acc[31], acc});
        prod = diff * $signed({1'b0, k});
        lpfStep = acc + prod[47:16];
    endfunction

    // two's complement to sign-magnitude, clamped to the full range
    function automatic logic [15:0] toSignMag(input logic signed [15:0] v);
        logic [15:0] mag;
        mag = v[15] ? 16'(-v) : 16'(v);
        if (mag > {1'b0, LDM_CUR_MAX_COUNT}) begin
            mag = {1'b0, LDM_CUR_MAX_COUNT};
        end
        toSignMag = {v[15], mag[14:0]};
    endfunction

    // saturate a 17 bit signed value into 16 bits
    function automatic logic signed [15:0] sat16(input logic signed [16:0] v);
        if (v[16] != v[15]) begin
            sat16 = v[16] ? 16'sh8000 : 16'sh7fff;
        end else begin
            sat16 = v[15:0];
        end
    endfunction

    function automatic logic selHit(
        input logic [LDM_ADDR_W-1:0] a,
        input logic [LDM_ADDR_W-1:0] loc
    );
        selHit = (a == loc);
    endfunction

    logic        [15:0] dcCoeff_ff;
    logic        [15:0] acCoeff_ff;
    logic signed [31:0] dcAcc_ff;
    logic signed [31:0] msAcc_ff;
    logic               msNew_ff;
    logic        [15:0] acResult_ff;
    logic        [15:0] peak_ff;
    logic        [15:0] loopCur_ff;
    logic        [15:0] longCur_ff;
    logic        [15:0] ringCur_ff;
    logic   [CNT_W-1:0] refreshCnt_ff;
    logic        [31:0] rootOp_ff;
    logic        [31:0] rootRes_ff;
    logic        [31:0] rootOne_ff;
    ldm_root_e          rootState_ff;
    logic        [15:0] ramRdData_ff;
    logic               ramRdValid_ff;
    logic   [SEL_W-1:0] monitorSel_ff;
    logic signed [15:0] dcNow;
    logic signed [15:0] acDev;
    logic        [31:0] acSquare;
    logic        [15:0] absSample;
    logic               refreshTick;
    logic        [15:0] coeffWrData;
    logic        [31:0] rootTry;

    assign dcNow       = dcAcc_ff[31:16];
    assign acDev       = sat16(17'(adcSample) - 17'(dcNow));
    assign acSquare    = 32'(acDev * acDev);
    assign absSample   = adcSample[15] ? 16'(-adcSample) : 16'(adcSample);
    assign refreshTick = (refreshCnt_ff == CNT_LAST);
    assign coeffWrData = ramWrData & LDM_COEFF_MASK;
    assign rootTry     = rootRes_ff + rootOne_ff;

    // selection is forwarded to the converter mux
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            monitorSel_ff <= '0;
        end else begin
            monitorSel_ff <= monitorInputSelect;
        end
    end

    // coefficient locations, low bits dropped on write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dcCoeff_ff <= LDM_RESET_VALUE;
            acCoeff_ff <= LDM_RESET_VALUE;
        end else if (ramWrEn) begin
            if (selHit(ramAddr, LDM_ADDR_DC_COEFF)) begin
                dcCoeff_ff <= coeffWrData;
            end
            if (selHit(ramAddr, LDM_ADDR_AC_COEFF)) begin
                acCoeff_ff <= coeffWrData;
            end
        end
    end

    // dc low-pass; a new sample wins over a software write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dcAcc_ff <= '0;
        end else if (adcValid) begin
            dcAcc_ff <= lpfStep(dcAcc_ff, {adcSample, 16'h0000},
                                dcCoeff_ff);
        end else if (ramWrEn && selHit(ramAddr, LDM_ADDR_DC_RES)) begin
            dcAcc_ff <= {ramWrData, 16'h0000};
        end
    end

    // mean square of the dc-removed signal feeds the root engine
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            msAcc_ff <= '0;
            msNew_ff <= 1'b0;
        end else begin
            if (adcValid) begin
                msAcc_ff <= lpfStep(msAcc_ff, acSquare, acCoeff_ff);
            end
            // a pending result is kept until the engine takes it
            if (adcValid) begin
                msNew_ff <= 1'b1;
            end else if (rootState_ff == LDM_ROOT_IDLE) begin
                msNew_ff <= 1'b0;
            end
        end
    end

    // bit-serial square root, one result bit per clock; slow enough
    // for the sub 300 Hz content this location is meant for
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rootState_ff <= LDM_ROOT_IDLE;
            rootOp_ff    <= '0;
            rootRes_ff   <= '0;
            rootOne_ff   <= '0;
            acResult_ff  <= LDM_RESET_VALUE;
        end else begin
            case (rootState_ff)
                LDM_ROOT_IDLE: begin
                    if (msNew_ff) begin
                        rootOp_ff    <= msAcc_ff[31] ? '0 : msAcc_ff;
                        rootRes_ff   <= '0;
                        rootOne_ff   <= LDM_ROOT_ONE_INIT;
                        rootState_ff <= LDM_ROOT_RUN;
                    end else if (ramWrEn &&
                                 selHit(ramAddr, LDM_ADDR_AC_RES)) begin
                        acResult_ff <= ramWrData;
                    end
                end
                LDM_ROOT_RUN: begin
                    if (rootOp_ff >= rootTry) begin
                        rootOp_ff  <= rootOp_ff - rootTry;
                        rootRes_ff <= (rootRes_ff >> 1) + rootOne_ff;
                    end else begin
                        rootRes_ff <= rootRes_ff >> 1;
                    end
                    rootOne_ff <= rootOne_ff >> 2;
                    if (rootOne_ff == LDM_ROOT_ONE_LAST) begin
                        acResult_ff  <= (rootOp_ff >= rootTry) ?
                            16'((rootRes_ff >> 1) + rootOne_ff) :
                            16'(rootRes_ff >> 1);
                        rootState_ff <= LDM_ROOT_IDLE;
                    end
                end
                default: begin
                    rootState_ff <= LDM_ROOT_IDLE;
                end
            endcase
        end
    end

    // peak follower: jumps up at once, decays slowly
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            peak_ff <= LDM_RESET_VALUE;
        end else if (adcValid) begin
            if (absSample > peak_ff) begin
                peak_ff <= absSample;
            end else begin
                peak_ff <= peak_ff - (peak_ff >> LDM_PEAK_DECAY_SH);
            end
        end else if (ramWrEn && selHit(ramAddr, LDM_ADDR_PEAK_RES)) begin
            peak_ff <= ramWrData;
        end
    end

    // free running refresh divider
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            refreshCnt_ff <= '0;
        end else if (refreshTick) begin
            refreshCnt_ff <= '0;
        end else begin
            refreshCnt_ff <= refreshCnt_ff + 1'b1;
        end
    end

    // real-time currents; refresh overrides a same-cycle write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            loopCur_ff <= LDM_RESET_VALUE;
            longCur_ff <= LDM_RESET_VALUE;
        end else if (refreshTick) begin
            loopCur_ff <= toSignMag(loopCurrentIn);
            longCur_ff <= toSignMag(longCurrentIn);
        end else if (ramWrEn) begin
            if (selHit(ramAddr, LDM_ADDR_LOOP_CUR)) begin
                loopCur_ff <= ramWrData;
            end
            if (selHit(ramAddr, LDM_ADDR_LONG_CUR)) begin
                longCur_ff <= ramWrData;
            end
        end
    end

    // ring transistor current kept in two's complement
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ringCur_ff <= LDM_RESET_VALUE;
        end else if (ringCurrentValid) begin
            ringCur_ff <= ringCurrentIn;
        end else if (ramWrEn && selHit(ramAddr, LDM_ADDR_RING_CUR)) begin
            ringCur_ff <= ramWrData;
        end
    end

    // registered read port, unmapped locations read zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ramRdData_ff  <= '0;
            ramRdValid_ff <= 1'b0;
        end else begin
            ramRdValid_ff <= ramRdEn;
            if (ramRdEn) begin
                case (ramAddr)
                    LDM_ADDR_LOOP_CUR: ramRdData_ff <= loopCur_ff;
                    LDM_ADDR_LONG_CUR: ramRdData_ff <= longCur_ff;
                    LDM_ADDR_RING_CUR: ramRdData_ff <= ringCur_ff;
                    LDM_ADDR_DC_RES:   ramRdData_ff <= dcNow;
                    LDM_ADDR_DC_COEFF: ramRdData_ff <= dcCoeff_ff;
                    LDM_ADDR_AC_RES:   ramRdData_ff <= acResult_ff;
                    LDM_ADDR_AC_COEFF: ramRdData_ff <= acCoeff_ff;
                    LDM_ADDR_PEAK_RES: ramRdData_ff <= peak_ff;
                    default:           ramRdData_ff <= '0;
                endcase
            end
        end
    end

    assign ramRdData     = ramRdData_ff;
    assign ramRdValid    = ramRdValid_ff;
    assign monitorSelOut = monitorSel_ff;
endmodule

`default_nettype wire

/* File: rtl/ldm_pkg.sv */
// constants for the line diagnostic measurement path
package ldm_pkg;
    // ram location indices
    localparam logic [7:0] LDM_ADDR_LOOP_CUR  = 8'h08;
    localparam logic [7:0] LDM_ADDR_LONG_CUR  = 8'h09;
    localparam logic [7:0] LDM_ADDR_RING_CUR  = 8'h12;
    localparam logic [7:0] LDM_ADDR_DC_RES    = 8'h33;
    localparam logic [7:0] LDM_ADDR_DC_COEFF  = 8'h34;
    localparam logic [7:0] LDM_ADDR_AC_RES    = 8'h35;
    localparam logic [7:0] LDM_ADDR_AC_COEFF  = 8'h36;
    localparam logic [7:0] LDM_ADDR_PEAK_RES  = 8'h37;

    localparam int          LDM_DATA_W        = 16;
    localparam int          LDM_ADDR_W        = 8;
    localparam logic [15:0] LDM_RESET_VALUE   = 16'h0000;
    // coefficient field sits in bits 15:3, bits 2:0 unused
    localparam logic [15:0] LDM_COEFF_MASK    = 16'hfff8;
    localparam int          LDM_ACC_FRAC      = 16;

    // current scaling: lsb in nA, full range in uA
    localparam int          LDM_CUR_LSB_NA    = 3097;
    localparam int          LDM_CUR_RANGE_UA  = 101090;
    localparam logic [14:0] LDM_CUR_MAX_COUNT =
        15'(64'(LDM_CUR_RANGE_UA) * 64'd1000 / 64'(LDM_CUR_LSB_NA));

    // refresh timing of the real-time current values
    localparam int          LDM_CLK_HZ        = 125_000_000;
    localparam int          LDM_REFRESH_HZ    = 800;
    localparam int          LDM_REFRESH_CYC   = LDM_CLK_HZ / LDM_REFRESH_HZ;

    // peak detector decay: drops by value >> this per sample
    localparam int          LDM_PEAK_DECAY_SH = 8;

    // square root engine
    localparam logic [31:0] LDM_ROOT_ONE_INIT = 32'h4000_0000;
    localparam logic [31:0] LDM_ROOT_ONE_LAST = 32'h0000_0001;

    typedef enum logic [1:0] {
        LDM_ROOT_IDLE = 2'b01,
        LDM_ROOT_RUN  = 2'b10
    } ldm_root_e;
endpackage

/* File: testbench/ldm_adc_model.sv */
// far-side model: monitor converter and current sense feeds
`timescale 1ns/10ps
`default_nettype none
module ldm_adc_model (
    input  wire logic          clk,
    output var logic signed [15:0] adcSample,
    output var logic           adcValid,
    output var logic signed [15:0] loopCurrentIn,
    output var logic signed [15:0] longCurrentIn,
    output var logic signed [15:0] ringCurrentIn,
    output var logic           ringCurrentValid
);
    // quiet outputs at time zero
    initial begin
        adcSample = 16'sh0000;
        adcValid = 1'b0;
        loopCurrentIn = 16'sh0000;
        longCurrentIn = 16'sh0000;
        ringCurrentIn = 16'sh0000;
        ringCurrentValid = 1'b0;
    end
    // data turns stale after the pulse, so a late latch sees garbage
    task automatic sample(input logic signed [15:0] x);
        adcSample = x;
        adcValid = 1'b1;
        @(posedge clk);
        #1;
        adcValid = 1'b0;
        adcSample = ~x;
    endtask
    task automatic ring(input logic signed [15:0] x);
        ringCurrentIn = x;
        ringCurrentValid = 1'b1;
        @(posedge clk);
        #1;
        ringCurrentValid = 1'b0;
        ringCurrentIn = ~x;
    endtask
    // currents are levels, sampled by the block on its own tick
    task automatic currents(input logic signed [15:0] lp, lg);
        loopCurrentIn = lp;
        longCurrentIn = lg;
    endtask
endmodule
`default_nettype wire

/* File: testbench/ldm_line_diag_measurement_bench.sv */
// self-checking bench for the diagnostic measurement block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, act) begin \
    numChecks++; \
    if ((act) !== (exp)) begin \
        errors++; \
        $display("unexpected %s exp %h got %h", nm, exp, act); \
    end \
end
module ldm_line_diag_measurement_bench;
    import ldm_pkg::*;
    localparam int SEL_W = 4;
    localparam int REF_CYC = 16;
    logic               clk = 1'b0;
    logic               rst_n = 1'b0;
    logic [7:0]         ramAddr = 8'h00;
    logic               ramWrEn = 1'b0;
    logic [15:0]        ramWrData = 16'h0000;
    logic               ramRdEn = 1'b0;
    logic [15:0]        ramRdData;
    logic               ramRdValid;
    logic [SEL_W-1:0]   selIn = 4'h0;
    logic [SEL_W-1:0]   selOut;
    logic signed [15:0] adcS, loopI, longI, ringI;
    logic               adcV, ringV;
    logic [15:0]        got;
    int                 errors = 0;
    int                 numChecks = 0;
    always #4 clk = ~clk;
    ldm_adc_model model_u (.clk(clk), .adcSample(adcS), .adcValid(adcV),
        .loopCurrentIn(loopI), .longCurrentIn(longI),
        .ringCurrentIn(ringI), .ringCurrentValid(ringV));
    ldm_line_diag_measurement #(.REFRESH_CYC(REF_CYC), .SEL_W(SEL_W)) dut_u (
        .clk(clk), .rst_n(rst_n), .ramAddr(ramAddr), .ramWrEn(ramWrEn),
        .ramWrData(ramWrData), .ramRdEn(ramRdEn), .ramRdData(ramRdData),
        .ramRdValid(ramRdValid), .monitorInputSelect(selIn),
        .monitorSelOut(selOut), .adcSample(adcS), .adcValid(adcV),
        .loopCurrentIn(loopI), .longCurrentIn(longI),
        .ringCurrentIn(ringI), .ringCurrentValid(ringV));
    // no gap after a write, so a read can follow at the next edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        ramAddr = a;
        ramWrData = d;
        ramWrEn = 1'b1;
        @(posedge clk);
        #1;
        ramWrEn = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        ramAddr = a;
        ramRdEn = 1'b1;
        @(posedge clk);
        #1;
        ramRdEn = 1'b0;
        got = ramRdData;
        `CHK("ramRdValid", 1'b1, ramRdValid)
        @(posedge clk);
        #1;
    endtask
    task automatic t_reset();
        logic [7:0] locs [8] = '{LDM_ADDR_LOOP_CUR, LDM_ADDR_LONG_CUR,
            LDM_ADDR_RING_CUR, LDM_ADDR_DC_RES, LDM_ADDR_DC_COEFF,
            LDM_ADDR_AC_RES, LDM_ADDR_AC_COEFF, LDM_ADDR_PEAK_RES};
        for (int i = 0; i < 8; i++) begin
            rd(locs[i]);
            `CHK("reset location", LDM_RESET_VALUE, got)
        end
        selIn = 4'h5;
        @(posedge clk);
        #1;
        `CHK("monitorSelOut", 4'h5, selOut)
        wr(8'h40, 16'hbeef);
        rd(8'h40);
        `CHK("unmapped", 16'h0000, got)
    endtask
    // dc filter halves the gap per sample; zero coefficient freezes it
    task automatic t_filters();
        logic signed [15:0] smp [4] = '{16'sd1000, 16'sd1000, -16'sd3000, 0};
        logic [15:0] dcExp [4] = '{16'h01f4, 16'h02ee, 16'h02ee, 16'h02ee};
        logic [15:0] pkExp [4] = '{16'h03e8, 16'h03e5, 16'h0bb8, 16'h0bad};
        wr(LDM_ADDR_DC_COEFF, 16'h8000);
        for (int i = 0; i < 4; i++) begin
            if (i == 2)
                wr(LDM_ADDR_DC_COEFF, 16'h0000);
            model_u.sample(smp[i]);
            rd(LDM_ADDR_PEAK_RES);
            `CHK("peak", pkExp[i], got)
            rd(LDM_ADDR_DC_RES);
            `CHK("dc", dcExp[i], got)
        end
        repeat (20) @(posedge clk);
        #1;
        rd(LDM_ADDR_AC_RES);
        `CHK("ac frozen", 16'h0000, got)
        wr(LDM_ADDR_AC_COEFF, 16'hffff);
        rd(LDM_ADDR_AC_COEFF);
        `CHK("ac coeff", 16'hfff8, got)
        model_u.sample(-16'sd3000);
        repeat (20) @(posedge clk);
        #1;
        rd(LDM_ADDR_AC_RES);
        // isqrt of 14062500 * 0xfff8 / 65536 gives 3749
        `CHK("ac rms", 16'h0ea5, got)
        wr(LDM_ADDR_DC_COEFF, 16'hffff);
        rd(LDM_ADDR_DC_COEFF);
        `CHK("dc coeff", 16'hfff8, got)
    endtask
    task automatic t_currents();
        model_u.currents(-16'sd100, 16'sh8000);
        model_u.ring(16'shfffb);
        rd(LDM_ADDR_RING_CUR);
        `CHK("ring", 16'hfffb, got)
        repeat (2 * REF_CYC) @(posedge clk);
        #1;
        rd(LDM_ADDR_LOOP_CUR);
        `CHK("loop", 16'h8064, got)
        rd(LDM_ADDR_LONG_CUR);
        `CHK("long clamped", 16'hff81, got)
        model_u.currents(16'sd300, 16'sd0);
        // poll until the refresh lands, then the next one is a period away
        for (int i = 0; i <= REF_CYC; i++) begin
            rd(LDM_ADDR_LOOP_CUR);
            if (got == 16'h012c)
                break;
        end
        `CHK("loop positive", 16'h012c, got)
        // a level change between ticks must not show before the next one
        model_u.currents(-16'sd5, 16'sd0);
        rd(LDM_ADDR_LOOP_CUR);
        `CHK("loop held", 16'h012c, got)
        repeat (REF_CYC) @(posedge clk);
        #1;
        rd(LDM_ADDR_LOOP_CUR);
        `CHK("loop refreshed", 16'h8005, got)
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", numChecks, errors);
        if (errors == 0 && numChecks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // watchdog cuts a hang short
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        $display("unexpected timeout exp %h got %h", 1'b0, 1'b1);
        wrap_up();
    end
    initial begin
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_filters();
        t_currents();
        wrap_up();
    end
endmodule
bind ldm_line_diag_measurement ldm_line_diag_measurement_checker
    #(.SEL_W(SEL_W)) chk_u (.clk(clk), .rst_n(rst_n), .ramAddr(ramAddr),
    .ramWrEn(ramWrEn), .ramWrData(ramWrData), .ramRdEn(ramRdEn),
    .ramRdData(ramRdData), .ramRdValid(ramRdValid),
    .monitorInputSelect(monitorInputSelect), .monitorSelOut(monitorSelOut),
    .adcSample(adcSample), .adcValid(adcValid),
    .loopCurrentIn(loopCurrentIn), .longCurrentIn(longCurrentIn),
    .ringCurrentIn(ringCurrentIn), .ringCurrentValid(ringCurrentValid));
`default_nettype wire

/* File: testbench/ldm_line_diag_measurement_checker.sv */
// port assertions for the diagnostic measurement block
`timescale 1ns/10ps
`default_nettype none
module ldm_line_diag_measurement_checker
    import ldm_pkg::*;
#(
    parameter int SEL_W = 4
) (
    input wire logic                          clk,
    input wire logic                          rst_n,
    input wire logic [ldm_pkg::LDM_ADDR_W-1:0] ramAddr,
    input wire logic                          ramWrEn,
    input wire logic [ldm_pkg::LDM_DATA_W-1:0] ramWrData,
    input wire logic                          ramRdEn,
    input wire logic [ldm_pkg::LDM_DATA_W-1:0] ramRdData,
    input wire logic                          ramRdValid,
    input wire logic [SEL_W-1:0]              monitorInputSelect,
    input wire logic [SEL_W-1:0]              monitorSelOut,
    input wire logic signed [15:0]            adcSample,
    input wire logic                          adcValid,
    input wire logic signed [15:0]            loopCurrentIn,
    input wire logic signed [15:0]            longCurrentIn,
    input wire logic signed [15:0]            ringCurrentIn,
    input wire logic                          ringCurrentValid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic signed [16:0] sampleWide;
    logic        [16:0] sampleMag;
    // 17 bits so the most negative sample keeps its magnitude
    always_comb begin
        sampleWide = 17'(adcSample);
        sampleMag  = sampleWide[16] ? 17'(-sampleWide) : 17'(sampleWide);
    end
    rd_valid_pulse_a: assert property (ramRdEn |=> ramRdValid)
        else $error("read strobe gave no valid pulse");
    rd_valid_only_a: assert property (!ramRdEn |=> !ramRdValid)
        else $error("valid pulse without a read");
    rd_data_hold_a: assert property (!ramRdEn |=> $stable(ramRdData))
        else $error("read data moved without a read");
    sel_copy_a: assert property ($past(rst_n) |->
        monitorSelOut == $past(monitorInputSelect))
        else $error("monitor select not passed on");
    coeff_low_zero_a: assert property (ramRdEn &&
        (ramAddr == LDM_ADDR_DC_COEFF || ramAddr == LDM_ADDR_AC_COEFF)
        |=> ramRdData[2:0] == 3'h0) else $error("coeff low bits not zero");
    dc_coeff_store_a: assert property (ramWrEn &&
        ramAddr == LDM_ADDR_DC_COEFF ##1 ramRdEn && !ramWrEn &&
        ramAddr == LDM_ADDR_DC_COEFF
        |=> ramRdData == ($past(ramWrData, 2) & LDM_COEFF_MASK))
        else $error("dc coefficient not kept");
    ac_coeff_store_a: assert property (ramWrEn &&
        ramAddr == LDM_ADDR_AC_COEFF ##1 ramRdEn && !ramWrEn &&
        ramAddr == LDM_ADDR_AC_COEFF
        |=> ramRdData == ($past(ramWrData, 2) & LDM_COEFF_MASK))
        else $error("ac coefficient not kept");
    ring_store_a: assert property (ringCurrentValid ##1
        ramRdEn && !ramWrEn && !ringCurrentValid &&
        ramAddr == LDM_ADDR_RING_CUR
        |=> ramRdData == $past(ringCurrentIn, 2))
        else $error("ring current not stored");
    peak_floor_a: assert property (adcValid ##1
        ramRdEn && !ramWrEn && !adcValid && ramAddr == LDM_ADDR_PEAK_RES
        // a sample equal to the held peak still lets it decay one step
        |=> {1'b0, ramRdData} >=
            $past(sampleMag - (sampleMag >> LDM_PEAK_DECAY_SH), 2))
        else $error("peak below decayed sample magnitude");
endmodule
`default_nettype wire
